// >>> xor_decode_pkg.sv
// constants and carrier types for the extended exclusive-or decoder
// assumes a single 25 MHz clock domain with synchronous reset
package xor_decode_pkg;

  // escape prefix and extended opcode
  localparam logic [7:0] ESC_BYTE = 8'hA5;
  localparam logic [7:0] EXT_OPCODE = 8'h6E;

  // sub-op nibbles of the second encoding byte, and the zero low nibble required in the third
  localparam logic [3:0] SUB_BYTE_DIR = 4'h3;
  localparam logic [3:0] SUB_WORD_DIR = 4'h7;
  localparam logic [3:0] SUB_AT_WORD = 4'h9;
  localparam logic [3:0] SUB_AT_DWORD = 4'hB;
  localparam logic [3:0] ZERO_NIB = 4'h0;

  // operand lengths in bytes
  localparam logic [2:0] BYTE_LEN = 3'h1;
  localparam logic [2:0] WORD_LEN = 3'h2;
  localparam logic [2:0] DWORD_LEN = 3'h4;

  // address widths and register file size
  localparam int INT_ADDR_W = 24;
  localparam int EXT_ADDR_W = 17;
  localparam int RF_BYTES = 32;
  localparam int RF_AW = 5;

  // narrow direct addresses at or above this base select registers
  localparam logic [7:0] SPECIAL_REG_BASE = 8'h80;

  // immediate fill patterns
  localparam logic [15:0] FILL_ZERO = 16'h0000;
  localparam logic [15:0] FILL_ONE = 16'hFFFF;

  // short immediate values
  localparam logic [2:0] SHORT_ONE = 3'h1;
  localparam logic [2:0] SHORT_TWO = 3'h2;
  localparam logic [2:0] SHORT_FOUR = 3'h4;

  // reset values
  localparam logic [23:0] DP_RESET = 24'h000000;
  localparam logic [23:0] ADDR_RESET = 24'h000000;

  typedef enum logic [1:0] {
    BR_BLOCK,
    BR_REGION,
    BR_FULL,
    BR_REL
  } br_kind_t;

  typedef struct packed {
    br_kind_t kind;
    logic [23:0] field;
    logic [23:0] next_pc;
  } br_req_t;

  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic done;
    logic other;
    logic bad;
    logic [15:0] value;
  } xor_result_t;

endpackage

// >>> reg_file_mem.sv
// byte-wide register file with one write port and a registered read
// assumes the caller sequences multi-byte operands one byte per cycle
`timescale 1ns/1ps
`default_nettype none
module reg_file_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // write port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  // read port
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);
  logic [7:0] mem [DEPTH];

  // cleared on reset so that a first operand is never unknown
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      for (int e = 0; e < DEPTH; e++) begin
        mem[e] <= 8'h00;
      end
    end else if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule
`default_nettype wire

// >>> phase_gen.sv
// two internal phases from the input clock, one state time per pair
// assumes the input clock is the oscillator input itself
`timescale 1ns/1ps
`default_nettype none
module phase_gen (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // phases
  output logic o_phase_one,
  output logic o_phase_two,
  output logic o_state_tick
);
  // halving: each phase lasts one input period
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_phase_one <= 1'b1;
      o_phase_two <= 1'b0;
      o_state_tick <= 1'b0;
    end else begin
      o_phase_one <= ~o_phase_one;
      o_phase_two <= o_phase_one;
      o_state_tick <= o_phase_one;
    end
  end

  AST_PHASE_ALT: assert property (
    @(posedge i_clock) disable iff (i_srst)
    o_phase_one |=> o_phase_two && !o_phase_one ##1 o_phase_one)
    else $error("phases do not alternate");
endmodule
`default_nettype wire

// >>> xor_decoder.sv
// extended exclusive-or decode and execute, plus operand helpers
// assumes code bytes and memory answers are synchronous to i_clock
`timescale 1ns/1ps
`default_nettype none
module xor_decoder (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // configuration
  input wire logic i_native_mode,
  input wire logic i_ext_addr_17,
  // code byte stream
  input wire logic i_code_valid,
  input wire logic [7:0] i_code_byte,
  output logic o_code_ready,
  // data memory
  output xor_decode_pkg::mem_req_t o_mem,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_rdata,
  output logic [16:0] o_ext_addr,
  // execution result
  output xor_decode_pkg::xor_result_t o_result,
  // immediate operands
  input wire logic [15:0] i_imm16,
  input wire logic [1:0] i_short_code,
  input wire logic i_sext_byte_mode,
  input wire logic [15:0] i_sext_data,
  output logic [31:0] o_zero_ext_imm,
  output logic [31:0] o_one_ext_imm,
  output logic [2:0] o_short_imm,
  output logic [31:0] o_sext_value,
  // branch targets
  input wire xor_decode_pkg::br_req_t i_branch,
  output logic [23:0] o_branch_target,
  // narrow direct address
  input wire logic [7:0] i_direct_addr_narrow,
  output logic o_special_function_reg,
  // data pointer
  input wire logic i_dp_wr_low,
  input wire logic i_dp_wr_ext,
  input wire logic [23:0] i_dp_data,
  output logic [23:0] o_data_pointer_ext,
  output logic [15:0] o_data_pointer_low,
  // timing phases
  output logic o_phase_one,
  output logic o_phase_two,
  output logic o_state_tick
);
  typedef enum logic [3:0] {
    S_IDLE, S_OP2, S_OP3, S_AHI, S_ALO, S_PTR, S_MEM, S_DST, S_WR
  } state_t;

  state_t state_reg, state_next;
  logic esc_reg, esc_next;
  logic ready_reg, ready_next;
  logic [3:0] sub_reg, sub_next;
  logic [3:0] ptr_nib_reg, ptr_nib_next;
  logic [3:0] breg_reg, breg_next;
  logic [7:0] ahi_reg, ahi_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [31:0] acc_reg, acc_next;
  logic [15:0] mval_reg, mval_next;
  logic [15:0] res_reg, res_next;
  logic mreq_reg, mreq_next;
  logic [23:0] maddr_reg, maddr_next;
  logic [16:0] ext_reg;
  logic done_next, other_next, bad_next;
  logic [23:0] dp_reg;

  // decoding and register file addressing
  wire take = i_code_valid & ready_reg;
  wire [3:0] lo_nib = i_code_byte[3:0];
  wire [3:0] hi_nib = i_code_byte[7:4];
  wire opens = i_native_mode | esc_reg;
  wire is_esc = (i_code_byte == xor_decode_pkg::ESC_BYTE);
  wire is_ext = (i_code_byte == xor_decode_pkg::EXT_OPCODE);
  wire word_op = (sub_reg == xor_decode_pkg::SUB_WORD_DIR);
  wire dword_ptr = (sub_reg == xor_decode_pkg::SUB_AT_DWORD);
  wire direct_op = (sub_reg == xor_decode_pkg::SUB_BYTE_DIR) | word_op;
  wire [2:0] dlen = word_op ? xor_decode_pkg::WORD_LEN
                            : xor_decode_pkg::BYTE_LEN;
  wire [2:0] plen = dword_ptr ? xor_decode_pkg::DWORD_LEN
                              : xor_decode_pkg::WORD_LEN;
  // register nibble scaled by operand size
  wire [4:0] ptr_base = dword_ptr ? {ptr_nib_reg[2:0], 2'b00}
                                  : {ptr_nib_reg, 1'b0};
  wire [4:0] dst_base = word_op ? {ptr_nib_reg, 1'b0}
                      : direct_op ? {1'b0, ptr_nib_reg}
                      : {1'b0, breg_reg};
  wire [4:0] rd_base = (state_reg == S_PTR) ? ptr_base : dst_base;
  wire [4:0] rf_raddr = 5'(rd_base + {2'b00, cnt_reg});
  wire [4:0] rf_waddr = 5'(dst_base + {2'b00, cnt_reg});
  wire rf_we = (state_reg == S_WR);
  // word result written high byte first
  wire [7:0] rf_wdata = (word_op && cnt_reg == 3'h0) ? res_reg[15:8]
                                                     : res_reg[7:0];
  wire [7:0] rf_rdata;
  wire [31:0] acc_shift = {acc_reg[23:0], rf_rdata};
  // pointer contents become a 24-bit internal address
  wire [23:0] ptr_addr = dword_ptr ? acc_shift[23:0]
                                   : {8'h00, acc_shift[15:0]};
  wire [15:0] dst_val = word_op ? acc_shift[15:0] : {8'h00, rf_rdata};
  wire [15:0] xor_val = dst_val ^ mval_reg;
  // external address from the internal one
  wire [16:0] ext_next = {i_ext_addr_17 & maddr_next[16],
                          maddr_next[15:0]};

  // operand helpers
  wire [31:0] zero_ext = {xor_decode_pkg::FILL_ZERO, i_imm16};
  wire [31:0] one_ext = {xor_decode_pkg::FILL_ONE, i_imm16};
  wire [2:0] short_val = (i_short_code == 2'b00) ? xor_decode_pkg::SHORT_ONE
                       : (i_short_code == 2'b01) ? xor_decode_pkg::SHORT_TWO
                       : xor_decode_pkg::SHORT_FOUR;
  wire [31:0] sext = i_sext_byte_mode
                   ? {{24{i_sext_data[7]}}, i_sext_data[7:0]}
                   : {{16{i_sext_data[15]}}, i_sext_data};
  wire [23:0] pc = i_branch.next_pc;
  wire [23:0] rel_off = {{16{i_branch.field[7]}}, i_branch.field[7:0]};
  wire [23:0] tgt_block = {pc[23:11], i_branch.field[10:0]};
  wire [23:0] tgt_region = {pc[23:16], i_branch.field[15:0]};
  wire [23:0] tgt_rel = 24'(pc + rel_off);
  wire [23:0] tgt = (i_branch.kind == xor_decode_pkg::BR_BLOCK) ? tgt_block
                  : (i_branch.kind == xor_decode_pkg::BR_REGION) ? tgt_region
                  : (i_branch.kind == xor_decode_pkg::BR_FULL)
                    ? i_branch.field : tgt_rel;
  wire narrow_sfr =
    (i_direct_addr_narrow >= xor_decode_pkg::SPECIAL_REG_BASE);

  reg_file_mem #(
    .DEPTH(xor_decode_pkg::RF_BYTES),
    .AW(xor_decode_pkg::RF_AW)
  ) u_rf (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_wr_en(rf_we),
    .i_wr_addr(rf_waddr),
    .i_wr_data(rf_wdata),
    .i_rd_addr(rf_raddr),
    .o_rd_data(rf_rdata)
  );

  phase_gen u_phase (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .o_phase_one(o_phase_one),
    .o_phase_two(o_phase_two),
    .o_state_tick(o_state_tick)
  );

  // sequencer
  always_comb begin
    state_next = state_reg;
    esc_next = esc_reg;
    sub_next = sub_reg;
    ptr_nib_next = ptr_nib_reg;
    breg_next = breg_reg;
    ahi_next = ahi_reg;
    cnt_next = cnt_reg;
    acc_next = acc_reg;
    mval_next = mval_reg;
    res_next = res_reg;
    mreq_next = mreq_reg;
    maddr_next = maddr_reg;
    done_next = 1'b0;
    other_next = 1'b0;
    bad_next = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (take) begin
          if (is_esc && !i_native_mode && !esc_reg) begin
            esc_next = 1'b1;
          end else if (is_ext && opens) begin
            esc_next = 1'b0;
            state_next = S_OP2;
          end else begin
            esc_next = 1'b0;
            other_next = 1'b1;
          end
        end
      end
      S_OP2: begin
        if (take) begin
          sub_next = lo_nib;
          ptr_nib_next = hi_nib;
          if (lo_nib == xor_decode_pkg::SUB_BYTE_DIR ||
              lo_nib == xor_decode_pkg::SUB_WORD_DIR) begin
            state_next = S_AHI;
          end else if (lo_nib == xor_decode_pkg::SUB_AT_WORD ||
                       lo_nib == xor_decode_pkg::SUB_AT_DWORD) begin
            state_next = S_OP3;
          end else begin
            other_next = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_OP3: begin
        if (take) begin
          breg_next = hi_nib;
          cnt_next = 3'h0;
          acc_next = 32'h0000_0000;
          if (lo_nib == xor_decode_pkg::ZERO_NIB) begin
            state_next = S_PTR;
          end else begin
            bad_next = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_AHI: begin
        if (take) begin
          ahi_next = i_code_byte;
          state_next = S_ALO;
        end
      end
      S_ALO: begin
        if (take) begin
          // wide direct operand starts in bank zero; a word's second byte can cross into bank one
          maddr_next = {8'h00, ahi_reg, i_code_byte};
          mreq_next = 1'b1;
          cnt_next = 3'h0;
          mval_next = 16'h0000;
          state_next = S_MEM;
        end
      end
      S_PTR: begin
        cnt_next = 3'(cnt_reg + 3'h1);
        if (cnt_reg != 3'h0) begin
          acc_next = acc_shift;
        end
        if (cnt_reg == plen) begin
          maddr_next = ptr_addr;
          mreq_next = 1'b1;
          cnt_next = 3'h0;
          mval_next = 16'h0000;
          state_next = S_MEM;
        end
      end
      S_MEM: begin
        if (i_mem_ack) begin
          // for a word operand the first byte fetched is the high byte
          mval_next = {mval_reg[7:0], i_mem_rdata};
          cnt_next = 3'(cnt_reg + 3'h1);
          if (cnt_reg == 3'(dlen - 3'h1)) begin
            mreq_next = 1'b0;
            cnt_next = 3'h0;
            acc_next = 32'h0000_0000;
            state_next = S_DST;
          end else begin
            maddr_next = 24'(maddr_reg + 24'h000001);
          end
        end
      end
      S_DST: begin
        cnt_next = 3'(cnt_reg + 3'h1);
        if (cnt_reg != 3'h0) begin
          acc_next = acc_shift;
        end
        if (cnt_reg == dlen) begin
          res_next = xor_val;
          cnt_next = 3'h0;
          state_next = S_WR;
        end
      end
      S_WR: begin
        cnt_next = 3'(cnt_reg + 3'h1);
        if (cnt_reg == 3'(dlen - 3'h1)) begin
          done_next = 1'b1;
          cnt_next = 3'h0;
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    ready_next = (state_next == S_IDLE) || (state_next == S_OP2) ||
                 (state_next == S_OP3) || (state_next == S_AHI) ||
                 (state_next == S_ALO);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= S_IDLE;
      esc_reg <= 1'b0;
      ready_reg <= 1'b0;
      sub_reg <= 4'h0;
      ptr_nib_reg <= 4'h0;
      breg_reg <= 4'h0;
      ahi_reg <= 8'h00;
      cnt_reg <= 3'h0;
      acc_reg <= 32'h0000_0000;
      mval_reg <= 16'h0000;
      res_reg <= 16'h0000;
      mreq_reg <= 1'b0;
      maddr_reg <= xor_decode_pkg::ADDR_RESET;
      ext_reg <= 17'h00000;
    end else begin
      state_reg <= state_next;
      esc_reg <= esc_next;
      ready_reg <= ready_next;
      sub_reg <= sub_next;
      ptr_nib_reg <= ptr_nib_next;
      breg_reg <= breg_next;
      ahi_reg <= ahi_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      mval_reg <= mval_next;
      res_reg <= res_next;
      mreq_reg <= mreq_next;
      maddr_reg <= maddr_next;
      ext_reg <= ext_next;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_result <= '0;
    end else begin
      o_result.done <= done_next;
      o_result.other <= other_next;
      o_result.bad <= bad_next;
      o_result.value <= done_next ? res_reg : o_result.value;
    end
  end

  // operand helper registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_zero_ext_imm <= 32'h0000_0000;
      o_one_ext_imm <= 32'h0000_0000;
      o_short_imm <= xor_decode_pkg::SHORT_ONE;
      o_sext_value <= 32'h0000_0000;
      o_branch_target <= 24'h000000;
      o_special_function_reg <= 1'b0;
    end else begin
      o_zero_ext_imm <= zero_ext;
      o_one_ext_imm <= one_ext;
      o_short_imm <= short_val;
      o_sext_value <= sext;
      o_branch_target <= tgt;
      o_special_function_reg <= narrow_sfr;
    end
  end

  // the low view is a slice of the extended pointer
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      dp_reg <= xor_decode_pkg::DP_RESET;
    end else if (i_dp_wr_ext) begin
      dp_reg <= i_dp_data;
    end else if (i_dp_wr_low) begin
      dp_reg <= {dp_reg[23:16], i_dp_data[15:0]};
    end
  end

  assign o_code_ready = ready_reg;
  assign o_mem = '{req: mreq_reg, addr: maddr_reg};
  assign o_ext_addr = ext_reg;
  assign o_data_pointer_ext = dp_reg;
  assign o_data_pointer_low = dp_reg[15:0];

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  sequence s_escaped_open;
    state_reg == S_IDLE && take && is_esc && !i_native_mode && !esc_reg
    ##1 take && is_ext;
  endsequence

  AST_ESC_OPENS: assert property (
    s_escaped_open |=> state_reg == S_OP2)
    else $error("escaped opcode not decoded");
  AST_NO_ESC_COMPAT: assert property (
    state_reg == S_IDLE && take && is_ext && !i_native_mode && !esc_reg
    |=> state_reg == S_IDLE && o_result.other)
    else $error("unescaped opcode accepted in compatibility mode");
  AST_DIRECT_LOW64K: assert property (
    $rose(mreq_reg) && direct_op |-> maddr_reg[23:16] == 8'h00)
    else $error("direct operand outside lowest 64K");
  AST_WORD_CONTIG: assert property (
    state_reg == S_MEM && i_mem_ack && word_op && cnt_reg == 3'h0
    |=> mreq_reg && maddr_reg == 24'($past(maddr_reg) + 24'h000001))
    else $error("word bytes not contiguous");
  AST_ZERO_EXT: assert property (
    1'b1 |=> o_zero_ext_imm == {16'h0000, $past(i_imm16)})
    else $error("zero extension wrong");
  AST_ONE_EXT: assert property (
    1'b1 |=> o_one_ext_imm == {16'hFFFF, $past(i_imm16)})
    else $error("one extension wrong");
  AST_SHORT_VAL: assert property (
    i_short_code == 2'b01 |=> o_short_imm == 3'h2)
    else $error("short immediate wrong");
  AST_BLOCK_TARGET: assert property (
    i_branch.kind == xor_decode_pkg::BR_BLOCK
    |=> o_branch_target[23:11] == $past(i_branch.next_pc[23:11]))
    else $error("block target left its block");
  AST_REL_TARGET: assert property (
    i_branch.kind == xor_decode_pkg::BR_REL && i_branch.field[7]
    |=> o_branch_target == 24'($past(i_branch.next_pc) - 24'h000100 +
                               {16'h0000, $past(i_branch.field[7:0])}))
    else $error("relative target wrong");
  AST_DP_SHARED: assert property (
    i_dp_wr_low && !i_dp_wr_ext |=> o_data_pointer_ext[23:16] ==
      $past(o_data_pointer_ext[23:16]) &&
      o_data_pointer_low == $past(i_dp_data[15:0]))
    else $error("low pointer write disturbed upper bits");
  AST_EXT_NARROW: assert property (
    !i_ext_addr_17 |=> !o_ext_addr[16])
    else $error("17th address bit driven in 16-bit mode");
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the extended exclusive-or decoder
// assumes a 25 MHz clock; the bench plays code source and data memory
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clock = 1'b0, i_srst = 1'b1, i_native_mode = 1'b1;
  logic i_ext_addr_17 = 1'b0, i_code_valid = 1'b0, i_mem_ack = 1'b0;
  logic [7:0] i_code_byte = 8'h00, i_mem_rdata = 8'h00;
  logic [7:0] i_direct_addr_narrow = 8'h00;
  logic [15:0] i_imm16 = 16'h0000, i_sext_data = 16'h0000;
  logic [1:0] i_short_code = 2'h0;
  logic i_sext_byte_mode = 1'b0, i_dp_wr_low = 1'b0, i_dp_wr_ext = 1'b0;
  logic [23:0] i_dp_data = 24'h000000;
  xor_decode_pkg::br_req_t i_branch = '0;
  xor_decode_pkg::mem_req_t o_mem;
  xor_decode_pkg::xor_result_t o_result;
  logic o_code_ready, o_special_function_reg;
  logic o_phase_one, o_phase_two, o_state_tick;
  logic [16:0] o_ext_addr;
  logic [31:0] o_zero_ext_imm, o_one_ext_imm, o_sext_value;
  logic [2:0] o_short_imm;
  logic [23:0] o_branch_target, o_data_pointer_ext;
  logic [15:0] o_data_pointer_low;
  int err_total = 0, num_checks = 0;

  always #20 i_clock = ~i_clock;

  xor_decoder dut_u (
    .i_clock(i_clock), .i_srst(i_srst), .i_native_mode(i_native_mode),
    .i_ext_addr_17(i_ext_addr_17), .i_code_valid(i_code_valid),
    .i_code_byte(i_code_byte), .o_code_ready(o_code_ready), .o_mem(o_mem),
    .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
    .o_ext_addr(o_ext_addr), .o_result(o_result), .i_imm16(i_imm16),
    .i_short_code(i_short_code), .i_sext_byte_mode(i_sext_byte_mode),
    .i_sext_data(i_sext_data), .o_zero_ext_imm(o_zero_ext_imm),
    .o_one_ext_imm(o_one_ext_imm), .o_short_imm(o_short_imm),
    .o_sext_value(o_sext_value), .i_branch(i_branch),
    .o_branch_target(o_branch_target),
    .i_direct_addr_narrow(i_direct_addr_narrow),
    .o_special_function_reg(o_special_function_reg),
    .i_dp_wr_low(i_dp_wr_low), .i_dp_wr_ext(i_dp_wr_ext),
    .i_dp_data(i_dp_data), .o_data_pointer_ext(o_data_pointer_ext),
    .o_data_pointer_low(o_data_pointer_low), .o_phase_one(o_phase_one),
    .o_phase_two(o_phase_two), .o_state_tick(o_state_tick)
  );

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bail();
    err_total++;
    end_sim();
  endtask

  task automatic cyc();
    @(negedge i_clock);
  endtask

  // hold the byte until the decoder takes it at a rising edge
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    cyc();
    i_code_valid = 1'b1;
    i_code_byte = b;
    while (o_code_ready !== 1'b1 && n < 60) begin
      cyc();
      n++;
    end
    if (n >= 60) bail();
    @(posedge i_clock);
  endtask

  task automatic idle();
    cyc();
    i_code_valid = 1'b0;
  endtask

  // sel 0 done, 1 other, 2 bad
  task automatic wait_res(input int sel);
    int n;
    n = 0;
    while (n < 60 && (sel == 0 ? o_result.done : sel == 1 ?
           o_result.other : o_result.bad) !== 1'b1) begin
      cyc();
      n++;
    end
    if (n >= 60) bail();
  endtask

  // more keeps the acknowledge up for a following byte of the operand
  task automatic serve(input logic [23:0] a, input logic [16:0] ea,
                       input logic [7:0] d, input logic more);
    int n;
    n = 0;
    while (o_mem.req !== 1'b1 && n < 60) begin
      cyc();
      n++;
    end
    if (n >= 60) bail();
    chk(o_mem.addr, a);
    chk(o_ext_addr, ea);
    i_mem_ack = 1'b1;
    i_mem_rdata = d;
    cyc();
    if (!more) i_mem_ack = 1'b0;
  endtask

  task automatic t_reset();
    repeat (2) cyc();
    chk({o_code_ready, o_mem.req, o_phase_one, o_short_imm}, 6'h09);
    chk(o_data_pointer_ext, 24'h000000);
    cyc();
    i_srst = 1'b0;
    repeat (2) cyc();
  endtask

  task automatic t_phase();
    int ticks;
    logic p;
    ticks = 0;
    for (int i = 0; i < 8; i++) begin
      p = o_phase_one;
      cyc();
      chk({o_phase_one, o_phase_two}, {~p, p});
      if (o_state_tick === 1'b1) ticks++;
    end
    chk(ticks, 4);
  endtask

  task automatic t_helpers();
    logic [23:0] pc, f, exp;
    i_imm16 = 16'h8001;
    i_sext_data = 16'h0080;
    i_sext_byte_mode = 1'b1;
    i_direct_addr_narrow = 8'h7F;
    cyc();
    chk(o_zero_ext_imm, 32'h00008001);
    chk(o_one_ext_imm, 32'hFFFF8001);
    chk(o_sext_value, 32'hFFFFFF80);
    chk(o_special_function_reg, 1'b0);
    i_sext_byte_mode = 1'b0;
    i_direct_addr_narrow = 8'h80;
    cyc();
    chk(o_sext_value, 32'h00000080);
    chk(o_special_function_reg, 1'b1);
    for (int k = 0; k < 4; k++) begin
      i_short_code = 2'(k);
      cyc();
      chk(o_short_imm, k == 0 ? 3'h1 : k == 1 ? 3'h2 : 3'h4);
    end
    pc = 24'h123FF0;
    f = 24'hABCDEF;
    for (int k = 0; k < 4; k++) begin
      i_branch.kind = xor_decode_pkg::br_kind_t'(k);
      i_branch.field = f;
      i_branch.next_pc = pc;
      exp = k == 0 ? {pc[23:11], f[10:0]} : k == 1 ? {pc[23:16], f[15:0]}
          : k == 2 ? f : pc + {{16{f[7]}}, f[7:0]};
      cyc();
      chk(o_branch_target, exp);
    end
    i_dp_data = 24'hC3A5F0;
    i_dp_wr_ext = 1'b1;
    cyc();
    i_dp_wr_ext = 1'b0;
    i_dp_data = 24'h001234;
    i_dp_wr_low = 1'b1;
    cyc();
    i_dp_wr_low = 1'b0;
    cyc();
    chk(o_data_pointer_ext, 24'hC31234);
    chk(o_data_pointer_low, 16'h1234);
  endtask

  task automatic t_byte_dir();
    send(8'h6E);
    send(8'h53);
    send(8'h12);
    send(8'h34);
    idle();
    serve(24'h001234, 17'h01234, 8'h5A, 1'b0);
    wait_res(0);
    chk(o_result.value, 16'h005A);
  endtask

  task automatic t_word_dir(input logic ext17, input logic [15:0] ev);
    i_ext_addr_17 = ext17;
    send(8'h6E);
    send(8'h27);
    send(8'hFF);
    send(8'hFF);
    idle();
    serve(24'h00FFFF, 17'h0FFFF, 8'hC3, 1'b1);
    serve(24'h010000, {ext17, 16'h0000}, 8'h96, 1'b0);
    wait_res(0);
    chk(o_result.value, ev);
  endtask

  task automatic t_compat();
    i_native_mode = 1'b0;
    send(8'h6E);
    idle();
    wait_res(1);
    send(8'hA5);
    send(8'h6E);
    send(8'h43);
    send(8'h00);
    send(8'h10);
    idle();
    serve(24'h000010, 17'h00010, 8'h3C, 1'b0);
    wait_res(0);
    chk(o_result.value, 16'h003C);
    i_native_mode = 1'b1;
    cyc();
    send(8'hA5);
    idle();
    wait_res(1);
  endtask

  task automatic t_indirect();
    send(8'h6E);
    send(8'h19);
    send(8'h51);
    idle();
    wait_res(2);
    send(8'h6E);
    send(8'h29);
    send(8'h50);
    idle();
    serve(24'h003C5A, 17'h03C5A, 8'h0F, 1'b0);
    wait_res(0);
    chk(o_result.value, 16'h0055);
    i_ext_addr_17 = 1'b1;
    send(8'h6E);
    send(8'h1B);
    send(8'h50);
    idle();
    serve(24'h550000, 17'h10000, 8'hAA, 1'b0);
    wait_res(0);
    chk(o_result.value, 16'h00FF);
  endtask

  initial begin
    t_reset();
    t_phase();
    t_helpers();
    t_byte_dir();
    t_word_dir(1'b1, 16'hC3CC);
    t_word_dir(1'b0, 16'h005A);
    t_compat();
    t_indirect();
    end_sim();
  end
endmodule
`default_nettype wire
